// >>> common/wake_cdr_pkg.sv
// Constants and types for the selective-wake and clock-recovery register bank
// Overview of operation
// - Options bit 7 picks the wake receiver, 0 for low-power and 1 for the standard receiver.
// - The wake receiver bit is only readable and writable while the trim unlock field is 11.
// - Reserved read-only bits (options 6:5, control-one 7:4 and 1, control-two 7:2) read as zero.
// - Oscillator calibration high and low bytes are read-only registers that ignore writes.
// - Filter code 00, 01, 10 in control-one bits 3:2 gives time constant 8, 16 and 32.
// - Filter code 11 adapts the constant to falling-edge distance: 2-3 gives 32, 4-8 16, 9-10 8.
// - Control-one bit 0 enables clock and data recovery when 1 and disables it when 0.
// - Control-two bits 1:0 pick a recovery clock of 80, 40, 20 or 10 MHz for codes 00 to 11.
// - A measured bit time above the upper clamp register is replaced by that clamp value.
// - A measured bit time below the lower clamp register is replaced by that clamp value.
// - Reset loads upper clamp a8, lower clamp 98 and control-one 04.
// - Each access is one 16-bit frame: 7-bit address, one mode bit, then a data byte.
package wake_cdr_pkg;

	localparam logic [6:0] OFF_OPTIONS = 7'h39;
	localparam logic [6:0] OFF_CAL_HIGH = 7'h3a;
	localparam logic [6:0] OFF_CAL_LOW = 7'h3b;
	localparam logic [6:0] OFF_CTRL_ONE = 7'h3c;
	localparam logic [6:0] OFF_CTRL_TWO = 7'h3d;
	localparam logic [6:0] OFF_UPPER = 7'h3e;
	localparam logic [6:0] OFF_LOWER = 7'h3f;

	localparam logic [7:0] RST_UPPER = 8'ha8;
	localparam logic [7:0] RST_LOWER = 8'h98;
	localparam logic [7:0] RST_CTRL_ONE = 8'h04;
	localparam logic [7:0] RST_CTRL_TWO = 8'h00;
	localparam logic [7:0] RST_OPTIONS = 8'h00;

	localparam int POS_WAKE_SEL = 7;
	localparam int POS_FILT_LO = 2;
	localparam int POS_ENABLE = 0;
	localparam int POS_MODE = 7;
	localparam int POS_DATA_LO = 8;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 8;

	localparam logic [1:0] TRIM_UNLOCKED = 2'h3;
	localparam logic [5:0] TC_8 = 6'h08;
	localparam logic [5:0] TC_16 = 6'h10;
	localparam logic [5:0] TC_32 = 6'h20;
	localparam logic [3:0] GAP_SHORT_MAX = 4'h3;
	localparam logic [3:0] GAP_MID_MAX = 4'h8;
	localparam logic [6:0] MHZ_80 = 7'h50;
	localparam logic [6:0] MHZ_40 = 7'h28;
	localparam logic [6:0] MHZ_20 = 7'h14;
	localparam logic [6:0] MHZ_10 = 7'h0a;

	typedef enum logic [1:0] {
		FILT_TC8,
		FILT_TC16,
		FILT_TC32,
		FILT_ADAPT
	} filt_code_t;

	// Settings handed to the recovery datapath
	typedef struct packed {
		logic recovery_enable;
		logic wake_receiver_select;
		logic [1:0] recovery_clock_select;
		logic [6:0] recovery_clock_mhz;
		logic [5:0] time_constant;
	} cdr_cfg_t;

endpackage

// >>> dv/selective_wake_cdr_config_tb.sv
// Self-checking bench for the wake and recovery register bank
`timescale 1ns/1ps
module selective_wake_cdr_config_tb;
	typedef struct {
		logic [6:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} row_t;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] trim_unlock = 2'h0;
	logic [3:0] edge_gap = 4'h5;
	logic [7:0] mbt = 8'h00;
	logic mv = 1'b0;
	logic csn, sclk, mosi, miso, btv;
	logic [7:0] btl, rdv;
	wake_cdr_pkg::cdr_cfg_t cfg;
	int n_mismatch = 0;
	int n_compared = 0;
	row_t rows [8] = '{'{7'h3e, 8'h55, 8'h55}, '{7'h3f, 8'haa, 8'haa},
		'{7'h3c, 8'hff, 8'h0d}, '{7'h3d, 8'hff, 8'h03}, '{7'h3a, 8'hff, 8'h5a},
		'{7'h3b, 8'h00, 8'ha5}, '{7'h39, 8'hf5, 8'h15}, '{7'h45, 8'hff, 8'h00}};
	logic [6:0] ra [5] = '{7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h39};
	logic [7:0] re [5] = '{8'h04, 8'h00, 8'ha8, 8'h98, 8'h15};
	logic [7:0] tc [3] = '{8'h08, 8'h10, 8'h20};
	logic [3:0] gap [6] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha};
	logic [7:0] gtc [6] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h08};
	logic [7:0] mhz [4] = '{8'h50, 8'h28, 8'h14, 8'h0a};
	logic [7:0] meas [5] = '{8'h60, 8'h40, 8'h54, 8'h4c, 8'h50};
	logic [7:0] clmp [5] = '{8'h54, 8'h4c, 8'h54, 8'h4c, 8'h50};

	always #20 sys_clk = ~sys_clk;

	wake_cdr_regs #(.OPTIONS_PRESET(5'h15)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .csn(csn), .sclk(sclk), .mosi(mosi),
		.miso(miso), .trim_unlock(trim_unlock), .osc_cal_high_in(8'h5a),
		.osc_cal_low_in(8'ha5), .edge_gap(edge_gap), .measured_bit_time(mbt),
		.measured_valid(mv), .bit_time_length_value(btl), .bit_time_valid(btv),
		.cfg(cfg));

	spi_host host (.sys_clk(sys_clk), .csn(csn), .sclk(sclk), .mosi(mosi), .miso(miso));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.xfer(16, a, 1'b1, d, x);
	endtask

	task automatic rd(input logic [6:0] a);
		host.xfer(16, a, 1'b0, 8'h00, rdv);
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------
	// Hang guard
	// ----------------
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		conclude();
	end

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			check(rdv, re[i]);
		end
		check({2'h0, cfg.time_constant}, 8'h10);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			check(rdv, rows[i].e);
		end
		$display("test register rows done");
		trim_unlock <= 2'h3;
		wr(7'h39, 8'h95);
		rd(7'h39);
		check(rdv, 8'h95);
		check({7'h0, cfg.wake_receiver_select}, 8'h01);
		trim_unlock <= 2'h0;
		rd(7'h39);
		check(rdv, 8'h15);
		trim_unlock <= 2'h3;
		wr(7'h39, 8'h15);
		trim_unlock <= 2'h0;
		$display("test trim lock done");
		for (int c = 0; c < 3; c++) begin
			wr(7'h3c, {4'h0, 2'(c), 2'b01});
			check({2'h0, cfg.time_constant}, tc[c]);
			check({7'h0, cfg.recovery_enable}, 8'h01);
		end
		wr(7'h3c, 8'h0c);
		check({7'h0, cfg.recovery_enable}, 8'h00);
		for (int i = 0; i < 6; i++) begin
			edge_gap <= gap[i];
			repeat (3) @(posedge sys_clk);
			check({2'h0, cfg.time_constant}, gtc[i]);
		end
		for (int c = 0; c < 4; c++) begin
			wr(7'h3d, 8'(c));
			check({1'b0, cfg.recovery_clock_mhz}, mhz[c]);
			check({6'h0, cfg.recovery_clock_select}, 8'(c));
		end
		$display("test filter and clock done");
		wr(7'h3d, 8'h01);
		wr(7'h3e, 8'h54);
		wr(7'h3f, 8'h4c);
		for (int i = 0; i < 5; i++) begin
			mv <= 1'b1;
			mbt <= meas[i];
			@(posedge sys_clk);
			mv <= 1'b0;
			#1;
			check({7'h0, btv}, 8'h01);
			check(btl, clmp[i]);
			@(posedge sys_clk);
		end
		#1;
		check({7'h0, btv}, 8'h00);
		check(btl, clmp[4]);
		$display("test clamp done");
		host.xfer(15, 7'h3e, 1'b1, 8'h00, rdv);
		rd(7'h3e);
		check(rdv, 8'h54);
		$display("test short frame done");
		resetn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(7'h3e);
		check(rdv, 8'ha8);
		check({2'h0, cfg.time_constant}, 8'h10);
		$display("test second reset done");
		conclude();
	end
endmodule

// >>> dv/spi_host.sv
// Host microcontroller model that issues register frames
`timescale 1ns/1ps
module spi_host (
	input wire logic sys_clk, // System clock
	output logic csn, // Frame select, active low
	output logic sclk, // Serial clock, idle low
	output logic mosi, // Serial data to the bank
	input wire logic miso // Serial data from the bank
);
	initial begin
		csn = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	task automatic xfer(input int nbits, input logic [6:0] a, input logic wr,
		input logic [7:0] d, output logic [7:0] rd);
		logic [15:0] f;
		f = {d, wr, a};
		rd = 8'h00;
		@(posedge sys_clk);
		csn <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi <= f[i];
			sclk <= 1'b0;
			// Three cycles low so the data bit has settled
			repeat (3) @(posedge sys_clk);
			if (i >= 8) begin
				rd[i - 8] = miso;
			end
			sclk <= 1'b1;
			repeat (2) @(posedge sys_clk);
		end
		sclk <= 1'b0;
		repeat (2) @(posedge sys_clk);
		csn <= 1'b1;
		// Released line must not keep the last bit
		mosi <= ~mosi;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// >>> rtl/wake_cdr_regs.sv
// Selective-wake and clock-recovery register bank with its serial frame port
`timescale 1ns/1ps
module wake_cdr_regs #(
	parameter logic [4:0] OPTIONS_PRESET = 5'h00 // Factory bits, arbitrary default
) (
	input wire logic sys_clk, // System clock, 25 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic csn, // Frame select, active low
	input wire logic sclk, // Serial clock, sampled
	input wire logic mosi, // Serial data in, LSB first
	output logic miso, // Serial data out
	input wire logic [1:0] trim_unlock, // Trim unlock field
	input wire logic [7:0] osc_cal_high_in, // Calibration high byte source
	input wire logic [7:0] osc_cal_low_in, // Calibration low byte source
	input wire logic [3:0] edge_gap, // Falling-edge distance in bits
	input wire logic [7:0] measured_bit_time, // Raw bit-time measurement
	input wire logic measured_valid, // Measurement strobe
	output logic [7:0] bit_time_length_value, // Clamped bit time
	output logic bit_time_valid, // Clamped value strobe
	output wake_cdr_pkg::cdr_cfg_t cfg // Recovery settings
);

	//------------------------------------------------------------
	// Register storage
	//------------------------------------------------------------
	logic wake_receiver_select;
	logic [1:0] filter_time_constant_select;
	logic recovery_enable;
	logic [1:0] recovery_clock_select;
	logic [7:0] bit_time_upper_limit;
	logic [7:0] bit_time_lower_limit;
	logic [7:0] osc_calibration_high_byte;
	logic [7:0] osc_calibration_low_byte;

	//------------------------------------------------------------
	// Frame receiver
	//------------------------------------------------------------
	logic sclk_prev;
	logic csn_prev;
	logic [4:0] bit_count;
	logic [15:0] frame;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic write_strobe;
	logic unlocked;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rd_byte;

	assign sclk_rise = !csn && sclk && !sclk_prev;
	assign sclk_fall = !csn && !sclk && sclk_prev;
	assign frame_end = csn && !csn_prev;
	assign addr = frame[6:0];
	assign wdata = frame[wake_cdr_pkg::POS_DATA_LO +: 8];
	assign unlocked = trim_unlock == wake_cdr_pkg::TRIM_UNLOCKED;
	// a frame of at least 16 clocks with mode bit set writes; clocks past 16 are ignored
	assign write_strobe = frame_end && bit_count == 5'(wake_cdr_pkg::FRAME_BITS)
		&& frame[wake_cdr_pkg::POS_MODE];

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sclk_prev <= 1'b0;
			csn_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk;
			csn_prev <= csn;
		end
	end

	// shift address, mode and data, LSB first
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bit_count <= 5'h00;
			frame <= 16'h0000;
		end else if (csn) begin
			bit_count <= 5'h00;
		end else if (sclk_rise && bit_count < 5'(wake_cdr_pkg::FRAME_BITS)) begin
			frame[bit_count[3:0]] <= mosi;
			bit_count <= bit_count + 5'h01;
		end
	end

	//------------------------------------------------------------
	// Read path
	//------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		case (addr)
			// locked selector reads as zero; bits 6:5 zero; preset
			wake_cdr_pkg::OFF_OPTIONS: rd_byte = {wake_receiver_select && unlocked,
				2'b00, OPTIONS_PRESET};
			wake_cdr_pkg::OFF_CAL_HIGH: rd_byte = osc_calibration_high_byte;
			wake_cdr_pkg::OFF_CAL_LOW: rd_byte = osc_calibration_low_byte;
			// reserved bits 7:4 and 1 stay zero
			wake_cdr_pkg::OFF_CTRL_ONE: rd_byte = {4'h0, filter_time_constant_select,
				1'b0, recovery_enable};
			wake_cdr_pkg::OFF_CTRL_TWO: rd_byte = {6'h00, recovery_clock_select};
			wake_cdr_pkg::OFF_UPPER: rd_byte = bit_time_upper_limit;
			wake_cdr_pkg::OFF_LOWER: rd_byte = bit_time_lower_limit;
			default: rd_byte = 8'h00;
		endcase
	end

	// Data byte goes out on the falling edge ahead of each data sample
	always_ff @(posedge sys_clk) begin
		if (!resetn || csn) begin
			miso <= 1'b0;
		end else if (sclk_fall && bit_count >= 5'(wake_cdr_pkg::ADDR_BITS)) begin
			miso <= rd_byte[bit_count[2:0]];
		end
	end

	//------------------------------------------------------------
	// Register writes
	//------------------------------------------------------------
	// receiver choice; written only while unlocked
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wake_receiver_select <= wake_cdr_pkg::RST_OPTIONS[wake_cdr_pkg::POS_WAKE_SEL];
		end else if (write_strobe && addr == wake_cdr_pkg::OFF_OPTIONS && unlocked) begin
			wake_receiver_select <= wdata[wake_cdr_pkg::POS_WAKE_SEL];
		end
	end

	// control-one resets to 04; reserved bits never stored
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			filter_time_constant_select <=
				wake_cdr_pkg::RST_CTRL_ONE[wake_cdr_pkg::POS_FILT_LO +: 2];
			recovery_enable <= wake_cdr_pkg::RST_CTRL_ONE[wake_cdr_pkg::POS_ENABLE];
		end else if (write_strobe && addr == wake_cdr_pkg::OFF_CTRL_ONE) begin
			filter_time_constant_select <= wdata[wake_cdr_pkg::POS_FILT_LO +: 2];
			recovery_enable <= wdata[wake_cdr_pkg::POS_ENABLE];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			recovery_clock_select <= wake_cdr_pkg::RST_CTRL_TWO[1:0];
		end else if (write_strobe && addr == wake_cdr_pkg::OFF_CTRL_TWO) begin
			recovery_clock_select <= wdata[1:0];
		end
	end

	// clamp limits reset to a8 and 98
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bit_time_upper_limit <= wake_cdr_pkg::RST_UPPER;
			bit_time_lower_limit <= wake_cdr_pkg::RST_LOWER;
		end else if (write_strobe) begin
			if (addr == wake_cdr_pkg::OFF_UPPER) begin
				bit_time_upper_limit <= wdata;
			end
			if (addr == wake_cdr_pkg::OFF_LOWER) begin
				bit_time_lower_limit <= wdata;
			end
		end
	end

	// calibration follows its source only; host writes ignored
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			osc_calibration_high_byte <= 8'h00;
			osc_calibration_low_byte <= 8'h00;
		end else begin
			osc_calibration_high_byte <= osc_cal_high_in;
			osc_calibration_low_byte <= osc_cal_low_in;
		end
	end

	//------------------------------------------------------------
	// Settings and clamp
	//------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cfg <= '0;
			cfg.time_constant <= wake_cdr_pkg::TC_16;
			cfg.recovery_clock_mhz <= wake_cdr_pkg::MHZ_80;
		end else begin
			// enable bit drives the recovery unit
			cfg.recovery_enable <= recovery_enable;
			cfg.wake_receiver_select <= wake_receiver_select;
			cfg.recovery_clock_select <= recovery_clock_select;
			case (recovery_clock_select)
				2'h0: cfg.recovery_clock_mhz <= wake_cdr_pkg::MHZ_80;
				2'h1: cfg.recovery_clock_mhz <= wake_cdr_pkg::MHZ_40;
				2'h2: cfg.recovery_clock_mhz <= wake_cdr_pkg::MHZ_20;
				default: cfg.recovery_clock_mhz <= wake_cdr_pkg::MHZ_10;
			endcase
			case (wake_cdr_pkg::filt_code_t'(filter_time_constant_select))
				wake_cdr_pkg::FILT_TC8: cfg.time_constant <= wake_cdr_pkg::TC_8;
				wake_cdr_pkg::FILT_TC16: cfg.time_constant <= wake_cdr_pkg::TC_16;
				wake_cdr_pkg::FILT_TC32: cfg.time_constant <= wake_cdr_pkg::TC_32;
				wake_cdr_pkg::FILT_ADAPT: begin
					if (edge_gap <= wake_cdr_pkg::GAP_SHORT_MAX) begin
						cfg.time_constant <= wake_cdr_pkg::TC_32;
					end else if (edge_gap <= wake_cdr_pkg::GAP_MID_MAX) begin
						cfg.time_constant <= wake_cdr_pkg::TC_16;
					end else begin
						cfg.time_constant <= wake_cdr_pkg::TC_8;
					end
				end
				default: cfg.time_constant <= wake_cdr_pkg::TC_16;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bit_time_length_value <= 8'h00;
			bit_time_valid <= 1'b0;
		end else begin
			bit_time_valid <= measured_valid;
			if (measured_valid) begin
				if (measured_bit_time > bit_time_upper_limit) begin
					bit_time_length_value <= bit_time_upper_limit;
				end else if (measured_bit_time < bit_time_lower_limit) begin
					bit_time_length_value <= bit_time_lower_limit;
				end else begin
					bit_time_length_value <= measured_bit_time;
				end
			end
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	clamp_upper_a: assert property (
		measured_valid && measured_bit_time > bit_time_upper_limit
		|=> bit_time_length_value == $past(bit_time_upper_limit))
		else $error("upper clamp not applied");
	clamp_lower_a: assert property (
		measured_valid && measured_bit_time < bit_time_lower_limit
		|=> bit_time_length_value == $past(bit_time_lower_limit))
		else $error("lower clamp not applied");
	fixed_filter_a: assert property (filter_time_constant_select == 2'h1 [*2]
		|-> cfg.time_constant == wake_cdr_pkg::TC_16)
		else $error("time constant 16 not selected");
	adapt_filter_a: assert property (
		filter_time_constant_select == 2'h3 && edge_gap >= 4'h9
		&& edge_gap <= 4'ha |=> cfg.time_constant == wake_cdr_pkg::TC_8)
		else $error("adaptive constant wrong for long gap");
	enable_follows_a: assert property ($rose(recovery_enable)
		|=> cfg.recovery_enable)
		else $error("recovery enable not passed on");
	clock_select_a: assert property (recovery_clock_select == 2'h1
		|=> cfg.recovery_clock_mhz == wake_cdr_pkg::MHZ_40)
		else $error("recovery clock frequency wrong");
	locked_select_a: assert property (write_strobe && addr == wake_cdr_pkg::OFF_OPTIONS
		&& !unlocked |=> $stable(wake_receiver_select))
		else $error("wake receiver written while locked");
	// Watches the serial output for reserved bits 1 and 7:4 of control-one
	reserved_zero_a: assert property (sclk_fall && addr == wake_cdr_pkg::OFF_CTRL_ONE
		&& (bit_count == 5'h09 || (bit_count >= 5'h0c && bit_count <= 5'h0f))
		|=> !miso)
		else $error("reserved bits read nonzero");
	upper_write_a: assert property (write_strobe && addr == wake_cdr_pkg::OFF_UPPER
		|=> bit_time_upper_limit == $past(wdata))
		else $error("upper limit write lost");
	cal_readonly_a: assert property (write_strobe && addr == wake_cdr_pkg::OFF_CAL_HIGH
		|=> osc_calibration_high_byte == $past(osc_cal_high_in))
		else $error("calibration byte changed by write");
	wake_pass_a: assert property (wake_receiver_select
		|=> cfg.wake_receiver_select)
		else $error("receiver choice not passed on");
	reset_values_a: assert property ($rose(resetn)
		|-> bit_time_upper_limit == wake_cdr_pkg::RST_UPPER
		&& bit_time_lower_limit == wake_cdr_pkg::RST_LOWER && recovery_enable == 1'b0)
		else $error("reset values wrong");

	write_frame_c: cover property (write_strobe);
	upper_clamp_c: cover property (measured_valid && measured_bit_time > bit_time_upper_limit);
	adapt_mode_c: cover property (filter_time_constant_select == 2'h3);
	unlocked_write_c: cover property (write_strobe && addr == wake_cdr_pkg::OFF_OPTIONS && unlocked);

endmodule
